// ===== verif/prc_regs_assertions.sv
`timescale 1ns/1ns
// ========================================
// control outputs checked against register writes
module prc_regs_checker (
    input wire        clk,
    input wire        rst,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        rxPowerDown,
    input wire        rxPolarityInvert,
    input wire        rxFallingEdge,
    input wire        rxSingleRail,
    input wire        rxUseAmi,
    input wire        rxCdrBypass,
    input wire        txUserTemplate,
    input wire [5:0]  txAmplitudeFactor
);
    reg       ph_ff, lnd_ff;
    reg [7:0] phA_ff, lndA_ff, d_ff;
    wire      cfgW = lnd_ff && lndA_ff == 8'h28;
    // follow a write from address phase to landing; data kept until next write
    always @(posedge clk) begin
        ph_ff   <= !rst && hsel && htrans[1] && hready && hwrite;
        lnd_ff  <= ph_ff;
        phA_ff  <= haddr[7:0];
        lndA_ff <= phA_ff;
        if (ph_ff)
            d_ff <= hwdata[7:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_pwr_dn_follow: assert property (cfgW |-> ##[1:3] rxPowerDown == d_ff[4])
        else $error("power down wrong");
    a_pol_follow: assert property (cfgW |-> ##[1:3] rxPolarityInvert == d_ff[3])
        else $error("polarity wrong");
    a_edge_follow: assert property (cfgW |-> ##[1:3]
        rxFallingEdge == (d_ff[2] && d_ff[1:0] != 2'h3)) else $error("edge wrong");
    a_rail_mode: assert property (cfgW |-> ##[1:3]
        rxSingleRail == !d_ff[1] && rxUseAmi == (d_ff[1:0] == 2'h1)) else $error("rail wrong");
    a_slicer_raw: assert property (cfgW |-> ##[1:3] rxCdrBypass == (d_ff[1:0] == 2'h3))
        else $error("slicer wrong");
    a_user_tmpl: assert property (lnd_ff && lndA_ff == 8'h18 |-> ##[1:3]
        txUserTemplate == (d_ff[3:2] == 2'h3)) else $error("template choice wrong");
    a_scale_follow: assert property (lnd_ff && lndA_ff == 8'h1c |-> ##[1:3]
        txAmplitudeFactor == d_ff[5:0]) else $error("scale wrong");
    a_reset_vals: assert property ($fell(rst) |-> !rxPowerDown && txAmplitudeFactor == 6'h21)
        else $error("reset values wrong");
endmodule
bind prc_regs prc_regs_checker u_prc_regs_checker (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .rxPowerDown, .rxPolarityInvert, .rxFallingEdge, .rxSingleRail, .rxUseAmi,
    .rxCdrBypass, .txUserTemplate, .txAmplitudeFactor);

// ===== verif/tb.sv
`timescale 1ns/1ns
// ========================================
// bench: register bus master and scenarios
module tb;
    reg         clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
    reg  [1:0]  htrans = 2'h0;
    reg  [2:0]  hsize = 3'h2;
    reg  [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    reg  [5:0]  tmplSampleAddr = 6'h0;
    wire [31:0] hrdata;
    wire        hreadyout, hresp, rxPowerDown, rxPolarityInvert, rxFallingEdge;
    wire        rxSingleRail, rxUseAmi, rxCdrBypass, txUserTemplate;
    wire [5:0]  txAmplitudeFactor;
    wire [6:0]  tmplSampleAmp;
    integer     nMismatch = 0, numChecks = 0, i;
    prc_regs u_prc_regs (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rxPowerDown, .rxPolarityInvert,
        .rxFallingEdge, .rxSingleRail, .rxUseAmi, .rxCdrBypass, .txUserTemplate,
        .txAmplitudeFactor, .tmplSampleAmp, .tmplSampleAddr);
    initial forever #5 clk = ~clk;
    task check(input [31:0] got, input [31:0] exp);
        begin
            numChecks = numChecks + 1;
            if (got !== exp) begin
                nMismatch = nMismatch + 1;
                $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
            end
        end
    endtask
    // one single transfer; hready is waited for in both phases
    task bus(input w, input [31:0] a, input [31:0] d);
        begin
            hsel <= 1'h1;
            htrans <= 2'h2;
            haddr <= a;
            hwrite <= w;
            @(posedge clk);
            while (hreadyout !== 1'h1) @(posedge clk);
            hsel <= 1'h0;
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge clk);
            while (hreadyout !== 1'h1) @(posedge clk);
            rd = hrdata;
        end
    endtask
    // start an indirect access, then poll until the start bit drops
    task launch(input [7:0] cmd);
        integer k;
        begin
            bus(1, 32'h20, cmd);
            rd = 32'h80;
            for (k = 0; k < 20 && rd[7] === 1'h1; k = k + 1) bus(0, 32'h20, 0);
            check(rd[7], 0);
        end
    endtask
    task t_reset;
        begin
            bus(0, 32'h28, 0);
            check(rd, 0);
            bus(0, 32'h1c, 0);
            check(rd, 32'h21);
            check({rxPowerDown, rxSingleRail, txAmplitudeFactor}, 8'h61);
            check({hreadyout, hresp}, 2'h2);
            $display("reset test done");
        end
    endtask
    task t_rxcfg;
        reg [7:0] v;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                v = {3'h7, i[2], ~i[0], i[1] | i[2], i[1:0]};
                bus(1, 32'h28, v);
                repeat (4) @(posedge clk);
                bus(0, 32'h28, 0);
                check(rd, v & 8'h1f);
                check({rxPowerDown, rxPolarityInvert, rxFallingEdge, rxSingleRail, rxUseAmi,
                    rxCdrBypass}, {v[4:3], v[2] && v[1:0] != 2'h3, ~v[1], v[1:0] == 2'h1,
                    v[1:0] == 2'h3});
            end
            $display("receiver config test done");
        end
    endtask
    task t_ram;
        reg [5:0] a;
        begin
            // four writes first, one in each interval (points 00, 15, 2a, 3f), then read them all back
            for (i = 0; i < 8; i = i + 1) begin
                a = i[1:0] * 6'h15;
                bus(1, 32'h24, i < 4 ? {25'h1, ~a[0], a} : 32'h0);
                launch({1'h1, i[2], a});
                bus(0, 32'h24, 0);
                if (i < 4) begin
                    tmplSampleAddr <= a;
                    repeat (2) @(posedge clk);
                    check(tmplSampleAmp, {~a[0], a});
                end else
                    check(rd, {~a[0], a});
            end
            $display("template ram test done");
        end
    endtask
    task t_tx;
        begin
            for (i = 1; i < 16; i = i + 2) begin
                bus(1, 32'h18, i);
                repeat (4) @(posedge clk);
                check(txUserTemplate, i[3:2] == 2'h3);
            end
            bus(1, 32'h1c, 32'hd5);
            repeat (4) @(posedge clk);
            check(txAmplitudeFactor, 6'h15);
            bus(1, 32'h3c, 32'hff);
            bus(0, 32'h3c, 0);
            check(rd, 0);
            $display("transmit config test done");
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", numChecks, nMismatch);
            if (nMismatch == 0 && numChecks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        t_reset;
        t_rxcfg;
        t_ram;
        t_tx;
        report_and_stop;
    end
    // watchdog: the tests need well under 1000 cycles
    initial begin
        #50000;
        nMismatch = nMismatch + 1;
        report_and_stop;
    end
endmodule

// ===== verilog/prc_defines.vh
`ifndef PRC_DEFINES_VH
`define PRC_DEFINES_VH
// register word offsets (byte address = 4 * index)
`define PRC_IDX_CMD          8'h08
`define PRC_IDX_DATA         8'h09
`define PRC_IDX_RXCFG        8'h0a
`define PRC_IDX_TXSHAPE      8'h06
`define PRC_IDX_SCALE        8'h07
// command register fields
`define PRC_CMD_START        7
`define PRC_CMD_DIR          6
// receiver configuration fields
`define PRC_RX_OFF           4
`define PRC_RX_INV           3
`define PRC_RX_EDGE          2
// reset values
`define PRC_CMD_RST          8'h00
`define PRC_RXCFG_RST        8'h00
`define PRC_SCALE_RST        6'h21
`define PRC_SHAPE_RST        4'h0
`define PRC_DATA_RST         7'h00
// decode codes
`define PRC_DEC_HDB3         2'b00
`define PRC_DEC_AMI          2'b01
`define PRC_DEC_DUAL         2'b10
`define PRC_DEC_SLICER       2'b11
`endif

// ===== verilog/prc_regs.v
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ns
`include "prc_defines.vh"
// What this block does
// - writing one to command bit 7 launches one template RAM access
// - command bit 6 picks direction: zero writes RAM, one reads RAM
// - command bits 5-4 select one of four unit intervals
// - command bits 3-0 select one of sixteen samples in the interval
// - indirect write stores data register bits 6-0 at the selected sample
// - indirect read places the stored amplitude in data register bits 6-0
// - receiver config bit 4 powers the receiver down; resets to zero
// - receiver config bit 3 inverts receive output data polarity
// - receiver config bit 2 picks rising or falling receive clock edge
// - slicer mode ignores the receive clock edge select bit
// - decode 00 gives HDB3/B8ZS decoded single-rail NRZ output
// - decode 01 gives AMI decoded single-rail NRZ output
// - decode 10 bypasses decoder, retimed dual-rail NRZ, recovery kept
// - decode 11 bypasses recovery and decoder, raw slicer RZ dual-rail
// - template RAM shapes pulses only when template choice is 11XX
// - user pulses scale by a six-bit factor resetting to 100001
module prc_regs #(
    parameter ADDR_W = 6
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg         rxPowerDown,
    output reg         rxPolarityInvert,
    output reg         rxFallingEdge,
    output reg         rxSingleRail,
    output reg         rxUseAmi,
    output reg         rxCdrBypass,
    output reg         txUserTemplate,
    output reg  [5:0]  txAmplitudeFactor,
    output reg  [6:0]  tmplSampleAmp,
    input  wire [ADDR_W-1:0] tmplSampleAddr
);
    // ========================================
    // register map
    // ========================================
    // byte 0x20 command: start, direction, interval index, point index
    // byte 0x24 data: seven-bit template amplitude, bit 7 reads zero
    // byte 0x28 receiver config: power down, polarity, edge, decode choice
    // byte 0x18 waveform template choice, four bits, resets to zero
    // byte 0x1c amplitude factor, six bits, resets to 100001
    // any other word reads zero and ignores writes
    // only byte lane 0 of each word is used; upper bits read zero
    // haddr bits above the index are not decoded, so the map aliases
    // bus timing: zero wait states; a write lands one edge after its data
    // phase, read data is captured in the address phase, so a read right
    // behind a write to the same word returns the old contents
    // an indirect access runs in the cycle after its start write lands;
    // software polls the start bit before touching the data register
    // the template ram has no reset: read back only what was written

    // ========================================
    // storage
    // ========================================
    reg [6:0] tmplRam [0:(1<<ADDR_W)-1];
    reg       cmdStart_ff;
    reg       cmdDir_ff;
    reg [1:0] intervalIndex_ff;
    reg [3:0] pointIndex_ff;
    reg [6:0] templateAmplitude_ff;
    reg [7:0] rxCfg_ff;
    reg [3:0] waveformTemplateChoice_ff;
    reg [5:0] amplitudeFactor_ff;
    reg       busWr_ff;
    reg       busRd_ff;
    reg [7:0] busIdx_ff;
    reg       accessBusy_ff;
    wire [5:0] ramAddr;
    wire       addrPhase;
    wire [7:0] wrByte;
    reg  [31:0] nxt_hrdata;
    wire       wrCmd;
    wire       wrData;
    wire       wrRxCfg;
    wire       wrShape;
    wire       wrScale;
    wire       startReq;
    wire [1:0] decodeSel;
    wire       slicerMode;

    assign ramAddr   = {intervalIndex_ff, pointIndex_ff};
    assign addrPhase = hsel & htrans[1] & hready;
    assign wrByte    = hwdata[7:0];

    // ========================================
    // bus address phase capture
    // ========================================
    // zero wait state slave; the phase registers feed the data phase
    always @(posedge clk) begin
        if (rst) begin
            busWr_ff  <= 1'b0;
            busRd_ff  <= 1'b0;
            busIdx_ff <= 8'h00;
        end else begin
            busWr_ff  <= addrPhase & hwrite;
            busRd_ff  <= addrPhase & ~hwrite;
            busIdx_ff <= haddr[9:2];
        end
    end

    // ========================================
    // register write strobes
    // ========================================
    // one strobe per register; the index was registered in the address phase
    assign wrCmd   = busWr_ff & (busIdx_ff == `PRC_IDX_CMD);
    assign wrData  = busWr_ff & (busIdx_ff == `PRC_IDX_DATA);
    assign wrRxCfg = busWr_ff & (busIdx_ff == `PRC_IDX_RXCFG);
    assign wrShape = busWr_ff & (busIdx_ff == `PRC_IDX_TXSHAPE);
    assign wrScale = busWr_ff & (busIdx_ff == `PRC_IDX_SCALE);
    // a start request while an access is still running is dropped,
    // so one write of the start bit never yields two accesses
    assign startReq = wrCmd & wrByte[`PRC_CMD_START] & ~accessBusy_ff;

    // ========================================
    // command register fields
    // ========================================
    // direction and address are taken on every command write, start or not
    always @(posedge clk) begin
        if (rst) begin
            cmdDir_ff        <= 1'b0;
            intervalIndex_ff <= 2'b00;
            pointIndex_ff    <= 4'h0;
        end else if (wrCmd) begin
            cmdDir_ff        <= wrByte[`PRC_CMD_DIR];
            intervalIndex_ff <= wrByte[5:4];
            pointIndex_ff    <= wrByte[3:0];
        end
    end

    // an access started by a bus write is carried out on the next edge,
    // so the start bit reads one for exactly one cycle after the write
    always @(posedge clk) begin
        if (rst) begin
            cmdStart_ff   <= 1'b0;
            accessBusy_ff <= 1'b0;
        end else if (startReq) begin
            cmdStart_ff   <= 1'b1;
            accessBusy_ff <= 1'b1;
        end else if (accessBusy_ff) begin
            cmdStart_ff   <= 1'b0;
            accessBusy_ff <= 1'b0;
        end
    end

    // ========================================
    // data and configuration registers
    // ========================================
    // data register: host write or indirect read result; a host write in
    // the completing cycle wins, since software asked for it last
    always @(posedge clk) begin
        if (rst) begin
            templateAmplitude_ff <= `PRC_DATA_RST;
        end else if (wrData) begin
            templateAmplitude_ff <= wrByte[6:0];
        end else if (accessBusy_ff && cmdDir_ff) begin
            templateAmplitude_ff <= tmplRam[ramAddr];
        end
    end

    // receiver config: reserved upper bits are never stored
    always @(posedge clk) begin
        if (rst) begin
            rxCfg_ff <= `PRC_RXCFG_RST;
        end else if (wrRxCfg) begin
            rxCfg_ff <= {3'b000, wrByte[4:0]};
        end
    end

    // waveform template choice, low nibble only
    always @(posedge clk) begin
        if (rst) begin
            waveformTemplateChoice_ff <= `PRC_SHAPE_RST;
        end else if (wrShape) begin
            waveformTemplateChoice_ff <= wrByte[3:0];
        end
    end

    // amplitude factor for user pulses, six bits
    always @(posedge clk) begin
        if (rst) begin
            amplitudeFactor_ff <= `PRC_SCALE_RST;
        end else if (wrScale) begin
            amplitudeFactor_ff <= wrByte[5:0];
        end
    end

    // template ram write port, uninitialised like a real macro
    always @(posedge clk) begin
        if (accessBusy_ff && !cmdDir_ff) begin
            tmplRam[ramAddr] <= templateAmplitude_ff;
        end
    end

    // ========================================
    // read mux
    // ========================================
    always @* begin
        nxt_hrdata = 32'h0000_0000;
        if (addrPhase && !hwrite) begin
            case (haddr[9:2])
                `PRC_IDX_CMD:     nxt_hrdata = {24'h00_0000, cmdStart_ff, cmdDir_ff,
                                                intervalIndex_ff, pointIndex_ff};
                `PRC_IDX_DATA:    nxt_hrdata = {25'h000_0000, templateAmplitude_ff};
                `PRC_IDX_RXCFG:   nxt_hrdata = {24'h00_0000, rxCfg_ff};
                `PRC_IDX_TXSHAPE: nxt_hrdata = {28'h000_0000, waveformTemplateChoice_ff};
                `PRC_IDX_SCALE:   nxt_hrdata = {26'h000_0000, amplitudeFactor_ff};
                default:          nxt_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ========================================
    // receive path decode
    // ========================================
    assign decodeSel  = rxCfg_ff[1:0];
    assign slicerMode = (decodeSel == `PRC_DEC_SLICER);

    // ========================================
    // bus response
    // ========================================
    // read data is sampled in the address phase; a read that directly
    // follows a write to the same register sees the old value
    always @(posedge clk) begin
        if (rst) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= nxt_hrdata;
            // no wait states and no error response: every access completes
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ========================================
    // receive path controls
    // ========================================
    // controls follow the configuration register one cycle later
    always @(posedge clk) begin
        if (rst) begin
            rxPowerDown      <= 1'b0;
            rxPolarityInvert <= 1'b0;
            rxFallingEdge    <= 1'b0;
            rxSingleRail     <= 1'b1;
            rxUseAmi         <= 1'b0;
            rxCdrBypass      <= 1'b0;
        end else begin
            rxPowerDown      <= rxCfg_ff[`PRC_RX_OFF];
            rxPolarityInvert <= rxCfg_ff[`PRC_RX_INV];
            // slicer output has no retiming clock, so the edge bit is moot
            rxFallingEdge    <= rxCfg_ff[`PRC_RX_EDGE] & ~slicerMode;
            // codes 00 and 01 decode onto one pin, 10 and 11 use both rails
            rxSingleRail     <= ~decodeSel[1];
            rxUseAmi         <= (decodeSel == `PRC_DEC_AMI);
            // slicer mode skips clock recovery as well as the decoder
            rxCdrBypass      <= slicerMode;
        end
    end

    // ========================================
    // transmit path controls
    // ========================================
    // any 11XX code selects the user template; the low two bits are
    // don't-care for the shaper, though they still read back as written
    always @(posedge clk) begin
        if (rst) begin
            txUserTemplate    <= 1'b0;
            txAmplitudeFactor <= `PRC_SCALE_RST;
        end else begin
            txUserTemplate    <= (waveformTemplateChoice_ff[3:2] == 2'b11);
            txAmplitudeFactor <= amplitudeFactor_ff;
        end
    end

    // ========================================
    // template sample port
    // ========================================
    // shaper side read port, one cycle of latency; it never stalls the
    // host side, as the ram has a separate write path
    always @(posedge clk) begin
        if (rst) begin
            tmplSampleAmp <= 7'h00;
        end else begin
            tmplSampleAmp <= tmplRam[tmplSampleAddr];
        end
    end
endmodule
